// [design/wwdt_top.sv]
// windowed watchdog timer with APB register slave
// assumes cpu_debug and cpu_idle come from logic on pclk; slow_clk is async
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none

module wwdt_top (
    input  wire logic        pclk,          // system clock, 100 MHz
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error, unmapped
    input  wire logic        slow_clk,      // slow clock pin
    input  wire logic        cpu_debug,     // processor in debug state
    input  wire logic        cpu_idle,      // system in idle mode
    output logic             wdog_fault,    // fault to reset controller
    output logic             reset_all,     // request all resets
    output logic             reset_proc,    // request processor reset only
    output logic             irq            // level interrupt
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [wwdt_pkg::DATA_W-1:0] cfg;
        logic                        locked;
        logic [wwdt_pkg::CNT_W-1:0]  cnt;
        logic [wwdt_pkg::FLAG_W-1:0] flags;
        logic [wwdt_pkg::FLAG_W-1:0] irqst;
        logic [wwdt_pkg::FLAG_W-1:0] mask;
        logic                        fault;
        logic                        rst_all;
        logic                        rst_proc;
        logic                        irq;
        logic                        pready;
        logic                        pslverr;
        logic [wwdt_pkg::DATA_W-1:0] prdata;
    } wwdt_state_type;

    wwdt_state_type s;
    wwdt_state_type next_s;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [wwdt_pkg::CNT_W-1:0] wwdt_value(input logic [31:0] cfg);
        wwdt_value = cfg[wwdt_pkg::VALUE_MSB:wwdt_pkg::VALUE_LSB];
    endfunction

    function automatic logic [wwdt_pkg::CNT_W-1:0] wwdt_delta(input logic [31:0] cfg);
        wwdt_delta = cfg[wwdt_pkg::DELTA_MSB:wwdt_pkg::DELTA_LSB];
    endfunction

    function automatic logic wwdt_is(input logic [7:0] addr, input logic [7:0] off);
        wwdt_is = (addr == off);
    endfunction

    function automatic logic wwdt_mapped(input logic [7:0] addr);
        wwdt_mapped = wwdt_is(addr, wwdt_pkg::OFF_RESTART_CONTROL)
                    | wwdt_is(addr, wwdt_pkg::OFF_WATCHDOG_CONFIG)
                    | wwdt_is(addr, wwdt_pkg::OFF_FAULT_FLAGS)
                    | wwdt_is(addr, wwdt_pkg::OFF_IRQ_STATUS)
                    | wwdt_is(addr, wwdt_pkg::OFF_IRQ_MASK);
    endfunction

    // ------------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------------
    logic                        setup;
    logic                        access;
    logic                        wr;
    logic                        rd;
    logic                        cfg_wr;
    logic                        restart;
    logic                        restart_ok;
    logic                        running;
    logic                        tick;
    logic                        unf_ev;
    logic                        err_ev;
    logic                        rd_flags;
    logic                        fie;
    logic                        rsten;
    logic                        proc_only;
    logic [wwdt_pkg::FLAG_W-1:0] reported;
    logic [wwdt_pkg::CNT_W-1:0]  value;
    logic [wwdt_pkg::CNT_W-1:0]  delta;

    assign value     = wwdt_value(s.cfg);
    assign delta     = wwdt_delta(s.cfg);
    assign fie       = s.cfg[wwdt_pkg::FIEN_BIT];
    assign rsten     = s.cfg[wwdt_pkg::RSTEN_BIT];
    assign proc_only = s.cfg[wwdt_pkg::PROC_BIT];
    assign reported  = s.prdata[wwdt_pkg::FLAG_W-1:0];

    // no wait state: ready comes from a flop set in the setup cycle
    assign setup  = psel && !penable;
    assign access = psel && penable && s.pready;
    assign wr     = access && pwrite && !s.pslverr;
    assign rd     = access && !pwrite && !s.pslverr;

    // later configuration writes fall on the floor silently
    assign cfg_wr = wr && wwdt_is(paddr, wwdt_pkg::OFF_WATCHDOG_CONFIG) && !s.locked;

    assign restart = wr && wwdt_is(paddr, wwdt_pkg::OFF_RESTART_CONTROL)
                  && (pwdata[wwdt_pkg::KEY_MSB:wwdt_pkg::KEY_LSB] == wwdt_pkg::RESTART_KEY)
                  && pwdata[wwdt_pkg::RESTART_BIT];

    // early restart is judged even with the watchdog disabled
    assign err_ev     = restart && (s.cnt > delta);
    assign restart_ok = restart && !err_ev;

    assign running = !s.cfg[wwdt_pkg::DIS_BIT]
                  && !(cpu_debug && s.cfg[wwdt_pkg::DBGHLT_BIT])
                  && !(cpu_idle && s.cfg[wwdt_pkg::IDLEHLT_BIT]);

    assign unf_ev   = tick && running && (s.cnt == '0);
    assign rd_flags = rd && wwdt_is(paddr, wwdt_pkg::OFF_FAULT_FLAGS);

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    wwdt_prescaler u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .slow_clk (slow_clk),
        .enable   (running),
        .restart  (restart_ok || cfg_wr),
        .tick     (tick)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [wwdt_pkg::FLAG_W-1:0] events;
        logic [wwdt_pkg::FLAG_W-1:0] flag_clr;
        logic [wwdt_pkg::FLAG_W-1:0] irq_clr;
        logic                        fault_set;
        events    = '0;
        flag_clr  = '0;
        irq_clr   = '0;
        fault_set = 1'b0;
        next_s    = s;

        // bus answer, latched in the setup cycle
        next_s.pready = setup;
        if (setup) begin
            next_s.pslverr = !wwdt_mapped(paddr);
            next_s.prdata  = '0;
            if (wwdt_is(paddr, wwdt_pkg::OFF_WATCHDOG_CONFIG)) begin
                next_s.prdata = s.cfg;
            end else if (wwdt_is(paddr, wwdt_pkg::OFF_FAULT_FLAGS)) begin
                next_s.prdata[wwdt_pkg::FLAG_W-1:0] = s.flags;
            end else if (wwdt_is(paddr, wwdt_pkg::OFF_IRQ_STATUS)) begin
                next_s.prdata[wwdt_pkg::FLAG_W-1:0] = s.irqst;
            end else if (wwdt_is(paddr, wwdt_pkg::OFF_IRQ_MASK)) begin
                next_s.prdata[wwdt_pkg::FLAG_W-1:0] = s.mask;
            end
        end else if (access) begin
            next_s.pslverr = 1'b0;
        end

        // configuration
        if (cfg_wr) begin
            next_s.cfg    = pwdata;
            next_s.locked = 1'b1;
        end
        if (wr && wwdt_is(paddr, wwdt_pkg::OFF_IRQ_MASK)) begin
            next_s.mask = pwdata[wwdt_pkg::FLAG_W-1:0];
        end

        // down counter
        if (cfg_wr) begin
            next_s.cnt = wwdt_value(pwdata);
        end else if (restart_ok) begin
            next_s.cnt = value;
        end else if (tick && running) begin
            if (s.cnt == '0) begin
                next_s.cnt = value;
            end else begin
                next_s.cnt = s.cnt - 12'h001;
            end
        end

        // sticky flags; only bits shown to the reader are cleared, set wins
        events[wwdt_pkg::UNF_BIT] = unf_ev;
        events[wwdt_pkg::ERR_BIT] = err_ev;
        if (rd_flags) begin
            flag_clr = reported;
            irq_clr  = reported;
        end
        if (wr && wwdt_is(paddr, wwdt_pkg::OFF_IRQ_STATUS)) begin
            irq_clr = irq_clr | pwdata[wwdt_pkg::FLAG_W-1:0];
        end
        next_s.flags = (s.flags & ~flag_clr) | events;
        next_s.irqst = (s.irqst & ~irq_clr) | events;

        // fault to the reset controller
        fault_set    = err_ev || (unf_ev && rsten);
        next_s.fault = (s.fault && !rd_flags) || fault_set;

        // reset requests and interrupt follow the new state
        next_s.rst_all  = next_s.fault && rsten && !proc_only;
        next_s.rst_proc = next_s.fault && rsten && proc_only;
        next_s.irq      = fie && ((next_s.irqst & next_s.mask) != '0);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // the reset controller feeds its watchdog reset back on presetn,
    // so flags, fault and lock all clear here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.cfg      <= wwdt_pkg::CONFIG_RESET;
            s.cnt      <= wwdt_pkg::CONFIG_RESET[wwdt_pkg::VALUE_MSB:wwdt_pkg::VALUE_LSB];
            s.flags    <= wwdt_pkg::FLAGS_RESET;
            s.mask     <= wwdt_pkg::MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign wdog_fault = s.fault;
    assign reset_all  = s.rst_all;
    assign reset_proc = s.rst_proc;
    assign irq        = s.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence wwdt_setup_seq;
        psel && !penable;
    endsequence

    sequence wwdt_cfg_attempt_seq;
        wr && wwdt_is(paddr, wwdt_pkg::OFF_WATCHDOG_CONFIG);
    endsequence

    a_apb_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
        wwdt_setup_seq |=> pready)
        else $error("ready not given one cycle after setup");

    a_cfg_write_once: assert property (@(posedge pclk) disable iff (!presetn)
        (wwdt_cfg_attempt_seq and s.locked) |=> $stable(s.cfg))
        else $error("locked configuration changed");

    a_cfg_reload_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr |=> (s.cnt == $past(pwdata[wwdt_pkg::VALUE_MSB:wwdt_pkg::VALUE_LSB])) && s.locked)
        else $error("configuration write did not reload counter");

    a_restart_reload: assert property (@(posedge pclk) disable iff (!presetn)
        restart_ok && !cfg_wr |=> s.cnt == $past(value))
        else $error("restart did not reload counter");

    a_bad_key_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && wwdt_is(paddr, wwdt_pkg::OFF_RESTART_CONTROL)
         && pwdata[wwdt_pkg::KEY_MSB:wwdt_pkg::KEY_LSB] != wwdt_pkg::RESTART_KEY) |-> !restart)
        else $error("restart taken with wrong key");

    a_unf_flag_fault: assert property (@(posedge pclk) disable iff (!presetn)
        unf_ev |=> s.flags[wwdt_pkg::UNF_BIT]
                   && (s.fault == ($past(rsten) || $past(err_ev) || ($past(s.fault) && !$past(rd_flags)))))
        else $error("underflow did not set flag or fault");

    a_early_error: assert property (@(posedge pclk) disable iff (!presetn)
        err_ev |=> s.flags[wwdt_pkg::ERR_BIT] && s.fault ##1 (s.fault || !$past(rd_flags)))
        else $error("early restart did not raise error");

    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        s.irq |-> $past(fie))
        else $error("interrupt without enable");

    a_reset_scope: assert property (@(posedge pclk) disable iff (!presetn)
        (s.rst_all |-> !$past(proc_only)) and (s.rst_proc |-> $past(proc_only)))
        else $error("reset request of wrong scope");

    a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rd_flags && !unf_ev && !err_ev |=> !s.fault && ((s.flags & $past(reported)) == '0))
        else $error("status read did not clear");

    a_halt_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !running && !restart_ok && !cfg_wr |=> $stable(s.cnt))
        else $error("counter moved while halted");

    a_tick_decrement: assert property (@(posedge pclk) disable iff (!presetn)
        tick && running && s.cnt != '0 && !restart_ok && !cfg_wr |=> s.cnt == $past(s.cnt) - 12'h001)
        else $error("counter did not decrement on tick");

    a_cfg_reset_value: assert property (@(posedge pclk) disable iff (!presetn)
        !s.locked |-> s.cfg == wwdt_pkg::CONFIG_RESET)
        else $error("unlocked configuration not at reset value");

    a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past one cycle");

    a_unf_reload: assert property (@(posedge pclk) disable iff (!presetn)
        unf_ev && !cfg_wr && !restart_ok |=> s.cnt == $past(value))
        else $error("underflow did not reload counter");

    a_fault_source: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s.fault) |-> $past(err_ev) || ($past(unf_ev) && $past(rsten)))
        else $error("fault raised without a cause");

    a_reset_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        (s.rst_all || s.rst_proc) |-> s.fault && $past(rsten))
        else $error("reset requested without enable");

    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        s.irq == ($past(fie) && ((s.irqst & s.mask) != '0)))
        else $error("interrupt does not follow unmasked status");

endmodule

`default_nettype wire

// [design/wwdt_pkg.sv]
// windowed watchdog timer: register map, field layout, reset values, constants
// assumes a 32-bit APB slave decoding byte offsets in the low address bits
package wwdt_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned CNT_W     = 12;
    localparam int unsigned FLAG_W    = 2;
    localparam int unsigned PRESC_W   = 7;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_RESTART_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_WATCHDOG_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FAULT_FLAGS     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS      = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK        = 8'h10;

    // ------------------------------------------------------------------
    // restart_control fields
    // ------------------------------------------------------------------
    localparam int unsigned       KEY_LSB       = 24;
    localparam int unsigned       KEY_MSB       = 31;
    localparam logic [7:0]        RESTART_KEY   = 8'hA5;
    localparam int unsigned       RESTART_BIT   = 0;

    // ------------------------------------------------------------------
    // watchdog_configuration fields
    // ------------------------------------------------------------------
    localparam int unsigned VALUE_LSB     = 0;
    localparam int unsigned VALUE_MSB     = 11;
    localparam int unsigned FIEN_BIT      = 12;
    localparam int unsigned RSTEN_BIT     = 13;
    localparam int unsigned PROC_BIT      = 14;
    localparam int unsigned DIS_BIT       = 15;
    localparam int unsigned DELTA_LSB     = 16;
    localparam int unsigned DELTA_MSB     = 27;
    localparam int unsigned DBGHLT_BIT    = 28;
    localparam int unsigned IDLEHLT_BIT   = 29;
    localparam logic [DATA_W-1:0] CONFIG_RESET = 32'h3FFF2FFF;

    // ------------------------------------------------------------------
    // fault_flags / irq_status / irq_mask layout
    // ------------------------------------------------------------------
    localparam int unsigned       UNF_BIT     = 0;
    localparam int unsigned       ERR_BIT     = 1;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 2'h0;
    localparam logic [FLAG_W-1:0] MASK_RESET  = 2'h3;

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    localparam int unsigned        PRESC_DIV  = 128;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);

endpackage

// [design/wwdt_prescaler.sv]
// slow clock divide-by-128 prescaler for the watchdog
// assumes slow_clk is asynchronous to pclk and far slower than it
`timescale 1ns/1ns
`default_nettype none

module wwdt_prescaler (
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    input  wire logic slow_clk, // slow clock pin, async
    input  wire logic enable,   // count slow edges
    input  wire logic restart,  // clear the divider
    output logic      tick      // one pclk pulse per 128 slow edges
);

    typedef struct packed {
        logic                           sync1;
        logic                           sync2;
        logic                           sync3;
        logic                           level;
        logic [wwdt_pkg::PRESC_W-1:0]   cnt;
        logic                           tick;
    } wwdt_presc_state_type;

    wwdt_presc_state_type s;
    wwdt_presc_state_type next_s;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s       = s;
        next_s.sync1 = slow_clk;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        next_s.tick  = 1'b0;
        // a level counts only once two stages agree
        if (s.sync2 == s.sync3) begin
            next_s.level = s.sync2;
        end
        if (restart) begin
            next_s.cnt = '0;
        end else if (enable && next_s.level && !s.level) begin
            if (s.cnt == wwdt_pkg::PRESC_LAST) begin
                next_s.cnt  = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_presc_tick_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        s.tick |-> ($past(s.cnt) == wwdt_pkg::PRESC_LAST) && (s.cnt == '0))
        else $error("prescaler tick without wrap");

endmodule

`default_nettype wire

// [verification/wwdt_reset_ctrl.sv]
// reset controller model facing the watchdog fault outputs
// assumes the bench ANDs rstn_out into the watchdog's presetn
`timescale 1ns/1ns
`default_nettype none

module wwdt_reset_ctrl (
    input  wire logic       pclk,       // system clock
    input  wire logic       reset_all,  // request all resets
    input  wire logic       reset_proc, // request processor reset only
    input  wire logic [3:0] lag,        // cycles before answering
    output logic            rstn_out    // reset pulse, active low
);
    logic [4:0] wait_cnt = 5'h00;
    logic [2:0] hold_cnt = 3'h0;

    // either scope resets the watchdog too; a slow answer leaves the request visible
    always_ff @(posedge pclk) begin
        if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
        end else if (wait_cnt == 5'h01) begin
            wait_cnt <= 5'h00;
            hold_cnt <= 3'h4;
        end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
        end else if (reset_all | reset_proc) begin
            wait_cnt <= {1'b0, lag} + 5'h01;
        end
    end
    assign rstn_out = (hold_cnt == 3'h0);
endmodule

`default_nettype wire

// [verification/windowed_watchdog_timer_test.sv]
// self-checking bench for the windowed watchdog timer
// drives slow_clk at a quarter of pclk; reset controller model closes the loop
`timescale 1ns/1ns
`default_nettype none

module windowed_watchdog_timer_test;
    logic        pclk       = 1'b0;
    logic        bench_rstn = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [1:0]  slow_ph    = 2'h0;
    logic        slow_clk;
    logic        cpu_debug  = 1'b0;
    logic        cpu_idle   = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, wdog_fault, reset_all, reset_proc, irq, ctrl_rstn, presetn, err;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          n, key, val, dlt, exp_cfg;

    assign presetn = bench_rstn & ctrl_rstn;
    initial forever #5 pclk = ~pclk;
    // slow clock at a quarter of pclk keeps the 128 divider short in simulation
    // each level lasts two pclk so the two agreeing sync stages can see it
    always @(posedge pclk) slow_ph <= slow_ph + 2'h1;
    assign slow_clk = slow_ph[1];

    wwdt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_clk(slow_clk), .cpu_debug(cpu_debug), .cpu_idle(cpu_idle), .wdog_fault(wdog_fault),
        .reset_all(reset_all), .reset_proc(reset_proc), .irq(irq));
    wwdt_reset_ctrl i_rstc (.pclk(pclk), .reset_all(reset_all), .reset_proc(reset_proc), .lag(4'h8),
        .rstn_out(ctrl_rstn));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // ready, read data and error are taken at the edge that samples ready high
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(negedge pclk);
    endtask

    task automatic wait_fault(input int lim);
        n = 0;
        while (wdog_fault !== 1'b1 && n < lim) begin @(negedge pclk); n++; end
    endtask

    task automatic do_reset();
        @(posedge pclk);
        bench_rstn <= 1'b0;
        repeat (3) @(posedge pclk);
        bench_rstn <= 1'b1;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        key = $urandom(32'hB7D8);
        do_reset();
        apb(0, 8'h04, 0); chk(rd, 32'h3FFF2FFF);
        apb(0, 8'h08, 0); chk(rd, 0);
        apb(0, 8'h14, 0); chk({rd[30:0], err}, 1);
        apb(1, 8'h00, 32'hA5000001); settle(); chk(wdog_fault, 0);
        // early restart inside a narrow window
        do_reset();
        val = $urandom_range(8'h7F, 8'h40);
        dlt = $urandom_range(15, 0);
        exp_cfg = val | (dlt << 16) | (1 << 12);
        apb(1, 8'h04, exp_cfg); apb(1, 8'h04, 32'h00000FFF); apb(0, 8'h04, 0); chk(rd, exp_cfg);
        key = $urandom_range(255, 0);
        if (key == 8'hA5) key = 8'h5A;
        apb(1, 8'h00, (key << 24) | 1); settle(); chk(wdog_fault, 0);
        apb(1, 8'h00, 32'hA5000001); settle(); chk({wdog_fault, irq, reset_all, reset_proc}, 4'hC);
        apb(1, 8'h10, 0); settle(); chk(irq, 0);
        apb(1, 8'h10, 3); settle(); chk(irq, 1);
        apb(1, 8'h0C, 2); settle(); chk({irq, wdog_fault}, 2'h1);
        apb(0, 8'h08, 0); chk(rd, 2); settle(); chk(wdog_fault, 0);
        apb(0, 8'h08, 0); chk(rd, 0);
        // underflow, both reset scopes, partner answers slowly
        for (int p = 0; p < 2; p++) begin
            do_reset();
            apb(1, 8'h04, 3 | (3 << 16) | (1 << 13) | (p << 14));
            wait_fault(3000);
            chk(n >= 4 * wwdt_pkg::PRESC_DIV * 4 - 24 && n <= 4 * wwdt_pkg::PRESC_DIV * 4 + 36, 1);
            chk({reset_proc, reset_all, irq}, {p[0], ~p[0], 1'b0});
            n = 0;
            while (presetn !== 1'b0 && n < 50) begin @(negedge pclk); n++; end
            while (presetn !== 1'b1 && n < 100) begin @(negedge pclk); n++; end
            apb(0, 8'h04, 0); chk(rd, 32'h3FFF2FFF);
            apb(0, 8'h08, 0); chk(rd, 0);
        end
        // disable, debug halt, idle halt (debug left high where only idle halts)
        for (int m = 0; m < 3; m++) begin
            do_reset();
            cpu_debug <= (m != 0);
            cpu_idle <= (m == 2);
            apb(1, 8'h04, 1 | (1 << 13) | (1 << (m == 0 ? 15 : (m == 1 ? 28 : 29))));
            repeat (1500) @(posedge pclk);
            cpu_idle <= 1'b0;
            if (m == 1) cpu_debug <= 1'b0;
            @(negedge pclk); chk(wdog_fault, 0);
            wait_fault(1100); chk(wdog_fault, m != 0);
            cpu_debug <= 1'b0;
            repeat (30) @(posedge pclk);
        end
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        complete_run();
    end
endmodule

`default_nettype wire
